// File: core/dma_buf_sequencer.sv
// Ping-pong A/B buffer sequencer for one DMA direction
`timescale 1ns/1ps
`default_nettype none
module dma_buf_sequencer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Software requests
    input wire logic clear,
    input wire logic [1:0] load_req,
    // Completion of the active buffer
    input wire logic done,
    // State
    output logic [1:0] load_q,
    output logic [1:0] active,
    output logic [1:0] load_evt
);
    serial_dma_pkg::seq_state_type state_q;
    serial_dma_pkg::seq_state_type state_d;
    logic [1:0] done_bit;

    // A load only counts when the buffer is idle; writing it again is moot
    assign load_evt = load_req & ~load_q & {2{~clear}};
    assign active = {state_q == serial_dma_pkg::SEQ_ON_B,
                     state_q == serial_dma_pkg::SEQ_ON_A};
    assign done_bit = active & {2{done}};

    // Pick the next buffer; A first, then alternate
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            serial_dma_pkg::SEQ_IDLE: begin
                if (load_q[0]) begin
                    state_d = serial_dma_pkg::SEQ_ON_A;
                end else if (load_q[1]) begin
                    state_d = serial_dma_pkg::SEQ_ON_B;
                end
            end
            serial_dma_pkg::SEQ_ON_A: begin
                if (done) begin
                    state_d = load_q[1] ? serial_dma_pkg::SEQ_ON_B
                                        : serial_dma_pkg::SEQ_IDLE;
                end
            end
            serial_dma_pkg::SEQ_ON_B: begin
                if (done) begin
                    state_d = load_q[0] ? serial_dma_pkg::SEQ_ON_A
                                        : serial_dma_pkg::SEQ_IDLE;
                end
            end
            default: state_d = serial_dma_pkg::SEQ_IDLE;
        endcase
        if (clear) begin
            state_d = serial_dma_pkg::SEQ_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= serial_dma_pkg::SEQ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Load bits self-clear on completion, all drop on direction reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_q <= 2'h0;
        end else if (clear) begin
            load_q <= 2'h0;
        end else begin
            load_q <= (load_q | load_evt) & ~done_bit;
        end
    end
endmodule // dma_buf_sequencer
`default_nettype wire

// File: core/serial_dma_consts.svh
// Register offsets, field positions, reset values of the serial DMA status
`ifndef SERIAL_DMA_CONSTS_SVH
`define SERIAL_DMA_CONSTS_SVH

// Byte offsets on the APB register bus
`define SDMA_CTRL_OFS 12'h000
`define SDMA_STATUS_OFS 12'h004
`define SDMA_INT_STATUS_OFS 12'h008
`define SDMA_INT_ENABLE_OFS 12'h00C
`define SDMA_INT_CLEAR_OFS 12'h010

// Control register fields
`define SDMA_CTRL_RX_LOAD_A 0
`define SDMA_CTRL_RX_LOAD_B 1
`define SDMA_CTRL_TX_LOAD_A 2
`define SDMA_CTRL_TX_LOAD_B 3
`define SDMA_CTRL_RX_RESET 4
`define SDMA_CTRL_TX_RESET 5

// Status register fields
`define SDMA_ST_RX_ACT_A 0
`define SDMA_ST_RX_ACT_B 1
`define SDMA_ST_TX_ACT_A 2
`define SDMA_ST_TX_ACT_B 3
`define SDMA_ST_OVR_A 4
`define SDMA_ST_OVR_B 5
`define SDMA_ST_PAR_A 6
`define SDMA_ST_PAR_B 7
`define SDMA_ST_FRM_A 8
`define SDMA_ST_FRM_B 9

// Interrupt event fields
`define SDMA_EV_RX_DONE_A 0
`define SDMA_EV_RX_DONE_B 1
`define SDMA_EV_TX_DONE_A 2
`define SDMA_EV_TX_DONE_B 3
`define SDMA_EV_RX_ERR 4
`define SDMA_EV_W 5

// Reset values
`define SDMA_STATUS_RST 16'h0000
`define SDMA_ZERO_WORD 32'h0000_0000

`endif

// File: core/serial_dma_pkg.sv
// Types shared by the serial DMA status block
`default_nettype none
package serial_dma_pkg;
    // Buffer sequencer state, one-hot
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_ON_A = 3'b010,
        SEQ_ON_B = 3'b100
    } seq_state_type;
endpackage
`default_nettype wire

// File: core/serial_dma_receive_status.sv
// APB-mapped A/B DMA control and receive status flags of a serial port
`include "serial_dma_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_dma_receive_status #(
    parameter int ADDR_W = 12
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Byte hand-off from the lower receive FIFO
    input wire logic rx_byte_valid,
    input wire logic rx_byte_frame_err,
    input wire logic rx_byte_parity_err,
    input wire logic rx_byte_overrun,
    output logic rx_byte_ready,
    // Completion of the active buffer in each direction
    input wire logic rx_buf_done,
    input wire logic tx_buf_done,
    // State toward the rest of the DMA
    output logic rx_active_buf_a,
    output logic rx_active_buf_b,
    output logic tx_active_buf_a,
    output logic tx_active_buf_b,
    output logic rx_dma_reset,
    output logic tx_dma_reset,
    // Interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic bus_access;
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic wr_ctrl;
    logic wr_int_en;
    logic wr_int_clr;
    logic rx_dma_reset_d;
    logic tx_dma_reset_d;
    logic [1:0] rx_load_req;
    logic [1:0] tx_load_req;
    logic [1:0] rx_load_q;
    logic [1:0] tx_load_q;
    logic [1:0] rx_act;
    logic [1:0] tx_act;
    logic [1:0] rx_load_evt;
    logic [1:0] rx_done_bit;
    logic [1:0] tx_done_bit;
    logic byte_taken;
    logic [5:0] err_set;
    logic [5:0] err_clr;
    logic [5:0] err_q;
    logic [`SDMA_EV_W-1:0] ev_set;
    logic [`SDMA_EV_W-1:0] ev_clr;
    logic [`SDMA_EV_W-1:0] ev_q;
    logic [`SDMA_EV_W-1:0] int_en_q;
    logic [15:0] status;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states keep the bench timing simple
    assign bus_access = psel & penable;
    assign wr_en = bus_access & pwrite;
    assign rd_en = psel & ~penable & ~pwrite; // Setup cycle of a read
    assign pready = 1'b1;
    assign addr_hit = (paddr == `SDMA_CTRL_OFS)
                    | (paddr == `SDMA_STATUS_OFS)
                    | (paddr == `SDMA_INT_STATUS_OFS)
                    | (paddr == `SDMA_INT_ENABLE_OFS)
                    | (paddr == `SDMA_INT_CLEAR_OFS);
    assign pslverr = bus_access & ~addr_hit;
    assign wr_ctrl = wr_en & (paddr == `SDMA_CTRL_OFS);
    assign wr_int_en = wr_en & (paddr == `SDMA_INT_ENABLE_OFS);
    assign wr_int_clr = wr_en & (paddr == `SDMA_INT_CLEAR_OFS);

    ////////////////////////////////////////////////////////////////////////
    // Control writes: one bits act, zero bits do nothing
    assign rx_dma_reset_d = wr_ctrl & pwdata[`SDMA_CTRL_RX_RESET];
    assign tx_dma_reset_d = wr_ctrl & pwdata[`SDMA_CTRL_TX_RESET];
    assign rx_load_req = {2{wr_ctrl}}
        & {pwdata[`SDMA_CTRL_RX_LOAD_B], pwdata[`SDMA_CTRL_RX_LOAD_A]};
    assign tx_load_req = {2{wr_ctrl}}
        & {pwdata[`SDMA_CTRL_TX_LOAD_B], pwdata[`SDMA_CTRL_TX_LOAD_A]};

    // Reset strobes pulse outward for one cycle and are never stored,
    // so the control bits read back as zero
    assign rx_dma_reset = rx_dma_reset_d;
    assign tx_dma_reset = tx_dma_reset_d;

    ////////////////////////////////////////////////////////////////////////
    // Buffer sequencing per direction
    dma_buf_sequencer u_rx_seq (
        .pclk(pclk),
        .presetn(presetn),
        .clear(rx_dma_reset_d),
        .load_req(rx_load_req),
        .done(rx_buf_done),
        .load_q(rx_load_q),
        .active(rx_act),
        .load_evt(rx_load_evt)
    );

    dma_buf_sequencer u_tx_seq (
        .pclk(pclk),
        .presetn(presetn),
        .clear(tx_dma_reset_d),
        .load_req(tx_load_req),
        .done(tx_buf_done),
        .load_q(tx_load_q),
        .active(tx_act),
        .load_evt()
    );

    assign rx_active_buf_a = rx_act[0];
    assign rx_active_buf_b = rx_act[1];
    assign tx_active_buf_a = tx_act[0];
    assign tx_active_buf_b = tx_act[1];
    assign rx_done_bit = rx_act & {2{rx_buf_done}};
    assign tx_done_bit = tx_act & {2{tx_buf_done}};

    ////////////////////////////////////////////////////////////////////////
    // Receive hand-off: with no buffer loaded the FIFO is held off and
    // fills; its overrun mark waits with the data for the next buffer
    assign rx_byte_ready = (|rx_act) & ~rx_dma_reset_d;
    assign byte_taken = rx_byte_valid & rx_byte_ready;

    // Error flags, ordered {frm_b, frm_a, par_b, par_a, ovr_b, ovr_a}
    assign err_set = {
        byte_taken & rx_act[1] & rx_byte_frame_err,
        byte_taken & rx_act[0] & rx_byte_frame_err,
        byte_taken & rx_act[1] & rx_byte_parity_err,
        byte_taken & rx_act[0] & rx_byte_parity_err,
        byte_taken & rx_act[1] & rx_byte_overrun,
        byte_taken & rx_act[0] & rx_byte_overrun
    };

    // A fresh load or a receive reset wipes that buffer's history
    // Same bit order as err_set, so B and A alternate from the top
    assign err_clr = {
        rx_load_evt[1] | rx_dma_reset_d,
        rx_load_evt[0] | rx_dma_reset_d,
        rx_load_evt[1] | rx_dma_reset_d,
        rx_load_evt[0] | rx_dma_reset_d,
        rx_load_evt[1] | rx_dma_reset_d,
        rx_load_evt[0] | rx_dma_reset_d
    };

    sticky_bits #(
        .W(6)
    ) u_err_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set(err_set),
        .clr(err_clr),
        .q(err_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status word
    always_comb begin
        status = `SDMA_STATUS_RST;
        status[`SDMA_ST_RX_ACT_A] = rx_act[0];
        status[`SDMA_ST_RX_ACT_B] = rx_act[1];
        status[`SDMA_ST_TX_ACT_A] = tx_act[0];
        status[`SDMA_ST_TX_ACT_B] = tx_act[1];
        status[`SDMA_ST_OVR_A] = err_q[0];
        status[`SDMA_ST_OVR_B] = err_q[1];
        status[`SDMA_ST_PAR_A] = err_q[2];
        status[`SDMA_ST_PAR_B] = err_q[3];
        status[`SDMA_ST_FRM_A] = err_q[4];
        status[`SDMA_ST_FRM_B] = err_q[5];
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events: completions and any new receive error
    assign ev_set[`SDMA_EV_RX_DONE_A] = rx_done_bit[0];
    assign ev_set[`SDMA_EV_RX_DONE_B] = rx_done_bit[1];
    assign ev_set[`SDMA_EV_TX_DONE_A] = tx_done_bit[0];
    assign ev_set[`SDMA_EV_TX_DONE_B] = tx_done_bit[1];
    assign ev_set[`SDMA_EV_RX_ERR] = |err_set;
    assign ev_clr = {`SDMA_EV_W{wr_int_clr}} & pwdata[`SDMA_EV_W-1:0];

    sticky_bits #(
        .W(`SDMA_EV_W)
    ) u_int_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set(ev_set),
        .clr(ev_clr),
        .q(ev_q)
    );

    // Interrupt enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en_q <= '0;
        end else if (wr_int_en) begin
            int_en_q <= pwdata[`SDMA_EV_W-1:0];
        end
    end

    // Level interrupt, high while an enabled event is pending
    assign irq = |(ev_q & int_en_q);

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped and write-only offsets read zero
    always_comb begin
        rd_word = `SDMA_ZERO_WORD;
        unique case (paddr)
            `SDMA_CTRL_OFS: rd_word[3:0] = {tx_load_q, rx_load_q};
            `SDMA_STATUS_OFS: rd_word[15:0] = status;
            `SDMA_INT_STATUS_OFS: rd_word[`SDMA_EV_W-1:0] = ev_q;
            `SDMA_INT_ENABLE_OFS: rd_word[`SDMA_EV_W-1:0] = int_en_q;
            default: rd_word = `SDMA_ZERO_WORD;
        endcase
    end

    // Read data is captured at the end of the setup cycle, so it stands
    // from a flop through the whole access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `SDMA_ZERO_WORD;
        end else if (rd_en) begin
            prdata <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence byte_into_b;
        byte_taken && rx_act[1];
    endsequence

    sequence byte_into_a;
        byte_taken && rx_act[0];
    endsequence

    sequence ctrl_write_one(int b);
        wr_ctrl && pwdata[b];
    endsequence

    frame_b_set_a: assert property (
        byte_into_b ##0 rx_byte_frame_err[*1] |=> status[`SDMA_ST_FRM_B])
        else $error("buffer B frame flag not set");

    frame_a_set_a: assert property (
        byte_into_a ##0 rx_byte_frame_err |=> status[`SDMA_ST_FRM_A])
        else $error("buffer A frame flag not set");

    ovr_b_set_a: assert property (
        byte_into_b ##0 rx_byte_overrun |=> status[`SDMA_ST_OVR_B])
        else $error("buffer B overrun flag not set");

    ovr_a_set_a: assert property (
        byte_into_a ##0 rx_byte_overrun |=> status[`SDMA_ST_OVR_A])
        else $error("buffer A overrun flag not set");

    ovr_held_a: assert property (
        !(|rx_act) |-> !rx_byte_ready ##1 !$rose(status[`SDMA_ST_OVR_A]))
        else $error("byte taken with no buffer loaded");

    clear_b_a: assert property (
        (rx_load_evt[1] || rx_dma_reset_d) && !(byte_taken && rx_act[1])
        |=> !status[`SDMA_ST_FRM_B] && !status[`SDMA_ST_PAR_B]
            && !status[`SDMA_ST_OVR_B])
        else $error("buffer B errors not cleared");

    clear_a_a: assert property (
        (rx_load_evt[0] || rx_dma_reset_d) && !(byte_taken && rx_act[0])
        |=> !status[`SDMA_ST_FRM_A] && !status[`SDMA_ST_PAR_A]
            && !status[`SDMA_ST_OVR_A])
        else $error("buffer A errors not cleared");

    parity_b_a: assert property (
        byte_into_b ##0 rx_byte_parity_err |=> status[`SDMA_ST_PAR_B])
        else $error("buffer B parity flag not set");

    load_clear_a: assert property (
        rx_buf_done && rx_act[0] && !rx_load_req[0] |=> !rx_load_q[0])
        else $error("load bit did not self-clear");

    load_start_a: assert property (
        wr_ctrl && pwdata[`SDMA_CTRL_RX_LOAD_A] && !rx_dma_reset_d
        && !rx_load_q[0] |=> rx_load_q[0] ##1 (rx_act != 2'h0))
        else $error("load did not start a buffer");

    rx_reset_a: assert property (
        ctrl_write_one(`SDMA_CTRL_RX_RESET)
        |=> rx_load_q == 2'h0 && rx_act == 2'h0 && !rx_dma_reset)
        else $error("receive reset left state behind");

    tx_reset_a: assert property (
        ctrl_write_one(`SDMA_CTRL_TX_RESET)
        |=> tx_load_q == 2'h0 && tx_act == 2'h0 && !tx_dma_reset)
        else $error("transmit reset left state behind");

    // Enabling an already pending event must raise the line next cycle
    irq_level_a: assert property (
        wr_int_en && (|(ev_q & pwdata[`SDMA_EV_W-1:0])) |=> irq)
        else $error("enabled event did not raise the interrupt");

    parity_a_set_a: assert property (
        byte_into_a ##0 rx_byte_parity_err |=> status[`SDMA_ST_PAR_A])
        else $error("buffer A parity flag not set");

    load_b_start_a: assert property (
        wr_ctrl && pwdata[`SDMA_CTRL_RX_LOAD_B] && !rx_dma_reset_d
        && !rx_load_q[1] |=> rx_load_q[1] ##1 (rx_act != 2'h0))
        else $error("load did not start buffer B");

    tx_start_a: assert property (
        wr_ctrl && pwdata[`SDMA_CTRL_TX_LOAD_A] && !tx_dma_reset_d
        && !tx_load_q[0] |=> tx_load_q[0] ##1 (tx_act != 2'h0))
        else $error("transmit load did not start a buffer");

    tx_done_clear_a: assert property (
        tx_buf_done && tx_act[0] && !tx_dma_reset_d |=> !tx_load_q[0])
        else $error("transmit load bit did not self-clear");

    // Set wins in the event bank, so no clear may swallow a new error
    err_event_a: assert property (
        (|err_set) |=> ev_q[`SDMA_EV_RX_ERR])
        else $error("receive error did not raise its event");
endmodule // serial_dma_receive_status
`default_nettype wire

// File: core/sticky_bits.sv
// Bank of sticky flags, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module sticky_bits #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Events and clears
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    genvar i;
    // One flop per flag; a same-cycle event is never lost
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    q[i] <= 1'b0;
                end else begin
                    q[i] <= set[i] | (q[i] & ~clr[i]);
                end
            end
        end
    endgenerate
endmodule // sticky_bits
`default_nettype wire

// File: test/rx_fifo_model.sv
// Model of the lower receive FIFO that hands bytes to the DMA
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_model (
    // Clock
    input wire logic pclk,
    // Byte hand-off toward the DMA
    input wire logic rx_byte_ready,
    output logic rx_byte_valid,
    output logic rx_byte_frame_err,
    output logic rx_byte_parity_err,
    output logic rx_byte_overrun
);
    ////////////////////////////////////////////////////////////////////////
    // Idle at time zero
    initial begin
        rx_byte_valid = 1'b0;
        rx_byte_frame_err = 1'b0;
        rx_byte_parity_err = 1'b0;
        rx_byte_overrun = 1'b0;
    end

    // Offer one byte and hold it until a loaded buffer takes it
    task automatic send(input logic f, input logic p, input logic o);
        @(posedge pclk);
        rx_byte_valid <= 1'b1;
        rx_byte_frame_err <= f;
        rx_byte_parity_err <= p;
        rx_byte_overrun <= o;
        // No buffer loaded means the error waits in the FIFO with its byte
        do @(posedge pclk); while (rx_byte_ready !== 1'b1);
        rx_byte_valid <= 1'b0;
        // Released tags show the inverse so stale values cannot pass
        rx_byte_frame_err <= ~f;
        rx_byte_parity_err <= ~p;
        rx_byte_overrun <= ~o;
    endtask
endmodule // rx_fifo_model
`default_nettype wire

// File: test/serial_dma_receive_status_test.sv
// Self-checking bench for the serial DMA status block
`include "serial_dma_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_dma_receive_status_test;
    ////////////////////////////////////////////////////////////////////////
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic rx_buf_done = 1'b0;
    logic tx_buf_done = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, rx_byte_ready, rx_byte_valid;
    logic frm, par, ovr, rx_act_a, rx_act_b, tx_act_a, tx_act_b;
    logic rx_rst, tx_rst, last_err;
    logic [1:0] last_rst;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;

    serial_dma_receive_status dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_byte_valid(rx_byte_valid), .rx_byte_frame_err(frm),
        .rx_byte_parity_err(par), .rx_byte_overrun(ovr),
        .rx_byte_ready(rx_byte_ready), .rx_buf_done(rx_buf_done),
        .tx_buf_done(tx_buf_done), .rx_active_buf_a(rx_act_a),
        .rx_active_buf_b(rx_act_b), .tx_active_buf_a(tx_act_a),
        .tx_active_buf_b(tx_act_b), .rx_dma_reset(rx_rst),
        .tx_dma_reset(tx_rst), .irq(irq)
    );

    rx_fifo_model fifo (
        .pclk(pclk), .rx_byte_ready(rx_byte_ready),
        .rx_byte_valid(rx_byte_valid), .rx_byte_frame_err(frm),
        .rx_byte_parity_err(par), .rx_byte_overrun(ovr)
    );

    ////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    // Cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; pulses and error are caught at the answer edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        last_rst = {tx_rst, rx_rst};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    // Idle cycle first so state started by the last write has settled
    task automatic rd(input string name, input logic [11:0] a,
                      input logic [31:0] exp);
        logic [31:0] r;
        @(posedge pclk);
        apb(1'b0, a, 32'h0000_0000, r);
        chk(name, r, exp);
    endtask

    task automatic pulse(input logic tx);
        @(posedge pclk);
        if (tx) tx_buf_done <= 1'b1;
        else rx_buf_done <= 1'b1;
        @(posedge pclk);
        tx_buf_done <= 1'b0;
        rx_buf_done <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd("status rst", `SDMA_STATUS_OFS, 32'h0000_0000);
        rd("ctrl rst", `SDMA_CTRL_OFS, 32'h0000_0000);
        wr(`SDMA_STATUS_OFS, 32'h0000_FFFF);
        rd("status ro", `SDMA_STATUS_OFS, 32'h0000_0000);
        chk("no slverr", {31'h0, last_err}, 32'h0000_0000);
        rd("unmapped", 12'h020, 32'h0000_0000);
        chk("slverr", {31'h0, last_err}, 32'h0000_0001);
        chk("pready", {31'h0, pready}, 32'h0000_0001);
        $display("test reset done");

        // Buffer A gets one byte of each error kind
        wr(`SDMA_CTRL_OFS, 32'h0000_0001);
        rd("ctrl load a", `SDMA_CTRL_OFS, 32'h0000_0001);
        chk("rx act a", {31'h0, rx_act_a}, 32'h0000_0001);
        fifo.send(1'b1, 1'b0, 1'b0);
        fifo.send(1'b0, 1'b1, 1'b0);
        fifo.send(1'b0, 1'b0, 1'b1);
        rd("flags a", `SDMA_STATUS_OFS, 32'h0000_0151);
        pulse(1'b0);
        rd("ctrl done a", `SDMA_CTRL_OFS, 32'h0000_0000);
        rd("flags kept", `SDMA_STATUS_OFS, 32'h0000_0150);
        $display("test buffer a done");

        // Overrun waits in the FIFO until buffer B is loaded
        fork
            fifo.send(1'b0, 1'b0, 1'b1);
            begin
                repeat (3) @(posedge pclk);
                chk("ready idle", {31'h0, rx_byte_ready}, 32'h0000_0000);
                wr(`SDMA_CTRL_OFS, 32'h0000_0002);
            end
        join
        fifo.send(1'b1, 1'b1, 1'b0);
        rd("flags b", `SDMA_STATUS_OFS, 32'h0000_03F2);
        chk("rx act b", {31'h0, rx_act_b}, 32'h0000_0001);
        wr(`SDMA_CTRL_OFS, 32'h0000_0000);
        rd("write zero", `SDMA_CTRL_OFS, 32'h0000_0002);
        wr(`SDMA_CTRL_OFS, 32'h0000_0001);
        rd("reload a", `SDMA_STATUS_OFS, 32'h0000_02A2);
        rd("a pending", `SDMA_CTRL_OFS, 32'h0000_0003);
        pulse(1'b0);
        rd("a follows b", `SDMA_STATUS_OFS, 32'h0000_02A1);
        wr(`SDMA_CTRL_OFS, 32'h0000_0010);
        chk("rx rst pulse", {30'h0, last_rst}, 32'h0000_0001);
        rd("rx rst flags", `SDMA_STATUS_OFS, 32'h0000_0000);
        rd("rx rst ctrl", `SDMA_CTRL_OFS, 32'h0000_0000);
        $display("test buffer b done");

        // Transmit loads, transmit reset, then the interrupt path
        wr(`SDMA_CTRL_OFS, 32'h0000_000C);
        rd("tx ctrl", `SDMA_CTRL_OFS, 32'h0000_000C);
        rd("tx act", `SDMA_STATUS_OFS, 32'h0000_0004);
        chk("tx act a", {31'h0, tx_act_a}, 32'h0000_0001);
        chk("tx act b", {31'h0, tx_act_b}, 32'h0000_0000);
        wr(`SDMA_CTRL_OFS, 32'h0000_0020);
        chk("tx rst pulse", {30'h0, last_rst}, 32'h0000_0002);
        rd("tx rst ctrl", `SDMA_CTRL_OFS, 32'h0000_0000);
        wr(`SDMA_INT_CLEAR_OFS, 32'h0000_001F);
        rd("int none", `SDMA_INT_STATUS_OFS, 32'h0000_0000);
        wr(`SDMA_CTRL_OFS, 32'h0000_0004);
        pulse(1'b1);
        rd("int tx a", `SDMA_INT_STATUS_OFS, 32'h0000_0004);
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        wr(`SDMA_INT_ENABLE_OFS, 32'h0000_0004);
        rd("int en", `SDMA_INT_ENABLE_OFS, 32'h0000_0004);
        chk("irq on", {31'h0, irq}, 32'h0000_0001);
        wr(`SDMA_INT_CLEAR_OFS, 32'h0000_0004);
        rd("int clear", `SDMA_INT_CLEAR_OFS, 32'h0000_0000);
        chk("irq off", {31'h0, irq}, 32'h0000_0000);
        $display("test transmit and interrupt done");
        summarize();
    end
endmodule // serial_dma_receive_status_test
`default_nettype wire
